// >>> hw/pac_defines.svh
// Register map, field positions and reset values of the pulse accumulator block
`ifndef PAC_DEFINES_SVH
`define PAC_DEFINES_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define PAC_ADDR_CHAN0      8'h00
`define PAC_ADDR_CHAN_LAST  8'h1C
`define PAC_ADDR_ACC_CTL    8'h20
`define PAC_ADDR_DIR_SEL    8'h24
`define PAC_ADDR_ACC_COUNT  8'h28
`define PAC_ADDR_ACC_FLAGS  8'h2C
`define PAC_ADDR_W          8

// ****************************************************************
// Field positions and widths
// ****************************************************************
`define PAC_CTL_W           7
`define PAC_FLAG_OVF_BIT    1
`define PAC_FLAG_IN_BIT     0
`define PAC_CHAN_N          8
`define PAC_CHAN_IDX_LSB    2
`define PAC_ACC_PIN_CHAN    7

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define PAC_CHAN_RST        16'h0000
`define PAC_CTL_RST         7'h00
`define PAC_DIR_RST         8'h00
`define PAC_COUNT_RST       16'h0000
`define PAC_COUNT_MAX       16'hFFFF
`define PAC_DIV256_MASK     16'h00FF
`define PAC_CLK_PRESC       2'h0
`define PAC_CLK_ACC         2'h1
`define PAC_CLK_ACC256      2'h2
`define PAC_CLK_ACC64K      2'h3
`define PAC_RESP_OKAY       2'h0
`define PAC_RESP_SLVERR     2'h2

`endif

// >>> hw/pac_pkg.sv
// Types shared by the pulse accumulator block
package pac_pkg;
   `include "pac_defines.svh"

   // Control register layout, bit 6 down to bit 0
   typedef struct packed {
      logic       accumulatorEnable;
      logic       accumulatorMode;
      logic       accumulatorEdgeSelect;
      logic [1:0] clockSelect;
      logic       accumulatorOverflowIrqEnable;
      logic       accumulatorInputIrqEnable;
   } pac_ctl_t;

   // Signals arriving from the timer core around this block
   typedef struct packed {
      logic        timerEnableBit;
      logic        prescTick;
      logic        presc64Tick;
      logic [15:0] freeCount;
   } pac_timer_t;

   // Register selected by an address
   typedef enum logic [2:0] {
      PAC_SEL_CHAN,
      PAC_SEL_CTL,
      PAC_SEL_DIR,
      PAC_SEL_COUNT,
      PAC_SEL_FLAGS,
      PAC_SEL_NONE
   } pac_sel_t;
endpackage : pac_pkg

// >>> hw/pac_regs.sv
// Channel value registers and pulse accumulator control with an AXI4-Lite slave
//
// Contract
// - capture counter on edge, else hold compare
// - value writes only land in compare mode
// - reset clears all channel value registers
// - bit 6 enables accumulator, independent of timer
// - accumulator input is channel 7 pin
// - bit 5 selects event or gated mode
// - event mode bit 4 picks falling/rising edge
// - gated edge 0: high passes tick, fall flags
// - gated edge 1: low passes tick, rise flags
// - bits 3:2 choose timer counter clock source
// - bit 1 enables overflow interrupt request
// - bit 0 enables input edge interrupt request
// - no divide-by-64 tick while timer disabled
// - accumulator disabled forces prescaler counter clock
// - clock select change takes effect immediately
// - control register at 0x20 always read/write
// - overflow flag set on count wrap to zero
// - pin synchronised to bus clock before counting
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps

module pac_regs
   import pac_pkg::*;
(
   input  wire logic                     core_clk,
   input  wire logic                     rst_b,
   // AXI4-Lite slave
   input  wire logic [`PAC_ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [`PAC_ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   // Timer core side
   input  wire pac_timer_t               timerIn,
   input  wire logic [`PAC_CHAN_N-1:0]   channelPin,
   output logic                          counterClkTick,
   output logic                          accumulatorClock,
   output logic                          accOverflowIrq,
   output logic                          accInputIrq
);

   // ****************************************************************
   // Address decode
   // ****************************************************************
   function automatic pac_sel_t addrDecode(input logic [`PAC_ADDR_W-1:0] addr);
      pac_sel_t sel;
      sel = PAC_SEL_NONE;
      if (addr[1:0] == 2'h0) begin
         if (addr <= `PAC_ADDR_CHAN_LAST) begin
            sel = PAC_SEL_CHAN;
         end else if (addr == `PAC_ADDR_ACC_CTL) begin
            sel = PAC_SEL_CTL;
         end else if (addr == `PAC_ADDR_DIR_SEL) begin
            sel = PAC_SEL_DIR;
         end else if (addr == `PAC_ADDR_ACC_COUNT) begin
            sel = PAC_SEL_COUNT;
         end else if (addr == `PAC_ADDR_ACC_FLAGS) begin
            sel = PAC_SEL_FLAGS;
         end
      end
      return sel;
   endfunction : addrDecode

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [15:0]             chanVal_r [`PAC_CHAN_N];
   pac_ctl_t                accCtl_r;
   logic [`PAC_CHAN_N-1:0]  channelDirectionSelect_r;
   logic [15:0]             accCount_r;
   logic [15:0]             divCount_r;
   logic                    ovfFlag_r;
   logic                    inFlag_r;
   logic [`PAC_CHAN_N-1:0]  pinMeta_r;
   logic [`PAC_CHAN_N-1:0]  pinSync_r;
   logic [`PAC_CHAN_N-1:0]  pinPrev_r;
   logic [`PAC_ADDR_W-1:0]  awAddr_r;
   logic                    awHeld_r;
   logic [31:0]             wData_r;
   logic [3:0]              wStrb_r;
   logic                    wHeld_r;

   // ****************************************************************
   // AXI4-Lite write channel
   // ****************************************************************
   logic     wrFire;
   pac_sel_t wrSel;
   logic [2:0] wrChan;

   // Address and data are taken in either order and held until both are in
   assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
   assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
   assign wrFire        = awHeld_r && wHeld_r;
   assign wrSel         = addrDecode(awAddr_r);
   assign wrChan        = awAddr_r[`PAC_CHAN_IDX_LSB +: 3];

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         awHeld_r <= 1'b0;
         awAddr_r <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld_r <= 1'b1;
         awAddr_r <= s_axi_awaddr;
      end else if (wrFire) begin
         awHeld_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         wHeld_r <= 1'b0;
         wData_r <= '0;
         wStrb_r <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld_r <= 1'b1;
         wData_r <= s_axi_wdata;
         wStrb_r <= s_axi_wstrb;
      end else if (wrFire) begin
         wHeld_r <= 1'b0;
      end
   end

   // Response one cycle after both halves are held; unmapped gives SLVERR
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `PAC_RESP_OKAY;
      end else if (wrFire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wrSel == PAC_SEL_NONE) ? `PAC_RESP_SLVERR : `PAC_RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ****************************************************************
   // Pin synchronisers and edge detection
   // ****************************************************************
   logic [`PAC_CHAN_N-1:0] pinRise;
   logic [`PAC_CHAN_N-1:0] pinFall;

   // Two flops before use; a pulse must be present at a rising clock edge to be seen
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pinMeta_r <= '0;
         pinSync_r <= '0;
         pinPrev_r <= '0;
      end else begin
         pinMeta_r <= channelPin;
         pinSync_r <= pinMeta_r;
         pinPrev_r <= pinSync_r;
      end
   end

   assign pinRise = pinSync_r & ~pinPrev_r;
   assign pinFall = ~pinSync_r & pinPrev_r;

   // ****************************************************************
   // Channel value registers
   // ****************************************************************
   // Capture uses rising edges; the per-channel edge control lives elsewhere
   genvar gi;
   generate
      for (gi = 0; gi < `PAC_CHAN_N; gi++) begin : gChan
         always_ff @(posedge core_clk) begin
            if (!rst_b) begin
               chanVal_r[gi] <= `PAC_CHAN_RST;
            end else if (!channelDirectionSelect_r[gi]) begin
               if (pinRise[gi]) begin
                  chanVal_r[gi] <= timerIn.freeCount;
               end
            end else if (wrFire && wrSel == PAC_SEL_CHAN && wrChan == 3'(gi)) begin
               // Byte lanes let a host write high then low byte
               if (wStrb_r[1]) begin
                  chanVal_r[gi][15:8] <= wData_r[15:8];
               end
               if (wStrb_r[0]) begin
                  chanVal_r[gi][7:0] <= wData_r[7:0];
               end
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Control and direction registers
   // ****************************************************************
   // Bit 7 is not stored at all, so it cannot be set
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         accCtl_r <= `PAC_CTL_RST;
      end else if (wrFire && wrSel == PAC_SEL_CTL && wStrb_r[0]) begin
         accCtl_r <= wData_r[`PAC_CTL_W-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         channelDirectionSelect_r <= `PAC_DIR_RST;
      end else if (wrFire && wrSel == PAC_SEL_DIR && wStrb_r[0]) begin
         channelDirectionSelect_r <= wData_r[`PAC_CHAN_N-1:0];
      end
   end

   // ****************************************************************
   // Accumulator clock and edge flag sources
   // ****************************************************************
   logic accPin;
   logic accEdge;
   logic gateOpen;
   logic flagEdge;

   assign accPin  = pinSync_r[`PAC_ACC_PIN_CHAN];
   // The selected edge counts; the same edge ends an active gate level
   assign accEdge = accCtl_r.accumulatorEdgeSelect ? pinRise[`PAC_ACC_PIN_CHAN]
                                                   : pinFall[`PAC_ACC_PIN_CHAN];
   assign flagEdge = accCtl_r.accumulatorEnable && accEdge;
   // Gate level: high for edge 0, low for edge 1
   assign gateOpen = accCtl_r.accumulatorEdgeSelect ? !accPin : accPin;

   // Event mode runs without the timer; gated mode needs the divide-by-64 tick and the timer enable
   always_comb begin
      accumulatorClock = 1'b0;
      if (accCtl_r.accumulatorEnable) begin
         if (accCtl_r.accumulatorMode) begin
            accumulatorClock = gateOpen && timerIn.presc64Tick
                               && timerIn.timerEnableBit;
         end else begin
            accumulatorClock = accEdge;
         end
      end
   end

   // ****************************************************************
   // Accumulator count and flags
   // ****************************************************************
   logic countWrite;
   logic flagClearOk;

   assign countWrite  = wrFire && wrSel == PAC_SEL_COUNT;
   // Flags clear only while the timer runs
   assign flagClearOk = wrFire && wrSel == PAC_SEL_FLAGS && wStrb_r[0]
                        && timerIn.timerEnableBit;

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         accCount_r <= `PAC_COUNT_RST;
      end else if (countWrite) begin
         accCount_r <= wData_r[15:0];
      end else if (accumulatorClock) begin
         accCount_r <= accCount_r + 16'h0001;
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         ovfFlag_r <= 1'b0;
      end else if (accumulatorClock && !countWrite && accCount_r == `PAC_COUNT_MAX) begin
         ovfFlag_r <= 1'b1;
      end else if (flagClearOk && wData_r[`PAC_FLAG_OVF_BIT]) begin
         ovfFlag_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         inFlag_r <= 1'b0;
      end else if (flagEdge) begin
         inFlag_r <= 1'b1;
      end else if (flagClearOk && wData_r[`PAC_FLAG_IN_BIT]) begin
         inFlag_r <= 1'b0;
      end
   end

   assign accOverflowIrq = ovfFlag_r && accCtl_r.accumulatorOverflowIrqEnable;
   assign accInputIrq    = inFlag_r && accCtl_r.accumulatorInputIrqEnable;

   // ****************************************************************
   // Timer counter clock select
   // ****************************************************************
   // Own divider so a count write does not disturb the divided clocks
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         divCount_r <= `PAC_COUNT_RST;
      end else if (accumulatorClock) begin
         divCount_r <= divCount_r + 16'h0001;
      end
   end

   // Purely combinational so a new selection acts on the next tick
   always_comb begin
      counterClkTick = timerIn.prescTick;
      if (accCtl_r.accumulatorEnable) begin
         case (accCtl_r.clockSelect)
            `PAC_CLK_PRESC:  counterClkTick = timerIn.prescTick;
            `PAC_CLK_ACC:    counterClkTick = accumulatorClock;
            `PAC_CLK_ACC256: counterClkTick = accumulatorClock
                             && (divCount_r & `PAC_DIV256_MASK) == `PAC_DIV256_MASK;
            `PAC_CLK_ACC64K: counterClkTick = accumulatorClock
                             && divCount_r == `PAC_COUNT_MAX;
            default:         counterClkTick = timerIn.prescTick;
         endcase
      end
   end

   // ****************************************************************
   // AXI4-Lite read channel
   // ****************************************************************
   pac_sel_t rdSel;
   logic [31:0] rdWord;

   assign s_axi_arready = !s_axi_rvalid;
   assign rdSel         = addrDecode(s_axi_araddr);

   // Unused upper bits read as zero
   always_comb begin
      rdWord = '0;
      case (rdSel)
         PAC_SEL_CHAN:  rdWord[15:0] = chanVal_r[s_axi_araddr[`PAC_CHAN_IDX_LSB +: 3]];
         PAC_SEL_CTL:   rdWord[`PAC_CTL_W-1:0] = accCtl_r;
         PAC_SEL_DIR:   rdWord[`PAC_CHAN_N-1:0] = channelDirectionSelect_r;
         PAC_SEL_COUNT: rdWord[15:0] = accCount_r;
         PAC_SEL_FLAGS: rdWord[1:0] = {ovfFlag_r, inFlag_r};
         default:       rdWord = '0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= `PAC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rdWord;
         s_axi_rresp  <= (rdSel == PAC_SEL_NONE) ? `PAC_RESP_SLVERR : `PAC_RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : pac_regs

// >>> dv/pac_timer_model.sv
// Timer core stand-in that feeds prescaler ticks and the free-running count
`timescale 1ns/1ps

module pac_timer_model
   import pac_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic timerOn,
   output pac_timer_t timerOut
);
   logic [5:0] divCnt_r;

   // ****************************************************************
   // Prescaler
   // ****************************************************************
   // Prescaler halves the bus clock; all stops while the timer is off
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         divCnt_r <= 6'h00;
         timerOut <= '0;
      end else begin
         divCnt_r                <= divCnt_r + {5'h00, timerOn};
         timerOut.timerEnableBit <= timerOn;
         timerOut.prescTick      <= timerOn & divCnt_r[0];
         timerOut.presc64Tick    <= timerOn & (divCnt_r == 6'h3F);
         timerOut.freeCount      <= timerOut.freeCount + {15'h0000, timerOn & divCnt_r[0]};
      end
   end
endmodule : pac_timer_model

// >>> dv/pac_regs_monitor.sv
// Concurrent checks on the ports of the pulse accumulator register block
`timescale 1ns/1ps
`include "pac_defines.svh"

module pac_regs_monitor
   import pac_pkg::*;
(
   input wire logic                   core_clk,
   input wire logic                   rst_b,
   input wire logic                   s_axi_awvalid,
   input wire logic                   s_axi_awready,
   input wire logic                   s_axi_wvalid,
   input wire logic                   s_axi_wready,
   input wire logic                   s_axi_bvalid,
   input wire logic                   s_axi_arvalid,
   input wire logic                   s_axi_arready,
   input wire logic                   s_axi_rvalid,
   input wire pac_timer_t             timerIn,
   input wire logic [`PAC_CHAN_N-1:0] channelPin,
   input wire logic                   counterClkTick,
   input wire logic                   accumulatorClock,
   input wire logic                   accOverflowIrq,
   input wire logic                   accInputIrq
);
   logic       pinPrev_r;
   logic [2:0] sincePin_r;

   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   // ****************************************************************
   // Helper logic
   // ****************************************************************
   // Cycles since the accumulator pin moved; saturates so a quiet pin never wraps back
   always_ff @(posedge core_clk) begin
      pinPrev_r <= channelPin[7];
      if (!rst_b) sincePin_r <= 3'h7;
      else if (channelPin[7] != pinPrev_r) sincePin_r <= 3'h0;
      else if (sincePin_r != 3'h7) sincePin_r <= sincePin_r + 3'h1;
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   chk_tick_source: assert property (counterClkTick |-> timerIn.prescTick || accumulatorClock)
      else $error("counter tick without a source tick");
   chk_acc_cause: assert property (accumulatorClock |-> timerIn.presc64Tick || sincePin_r <= 3'h4)
      else $error("accumulator strobe without pin edge or gated tick");
   chk_in_irq_cause: assert property ($rose(accInputIrq) |-> sincePin_r <= 3'h4 || s_axi_bvalid)
      else $error("input irq rose without pin edge or register write");
   chk_ovf_cause: assert property ($rose(accOverflowIrq) |-> $past(accumulatorClock) || s_axi_bvalid)
      else $error("overflow irq rose without an increment");
   chk_rst_presc: assert property (disable iff (1'h0) !rst_b |=> counterClkTick == timerIn.prescTick)
      else $error("counter tick not from prescaler after reset");
   chk_rst_irq: assert property (disable iff (1'h0) !rst_b |=> !accOverflowIrq && !accInputIrq)
      else $error("irq active after reset");
   chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write not answered in two cycles");
endmodule : pac_regs_monitor

bind pac_regs pac_regs_monitor pac_regs_monitor_inst (
   .core_clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .timerIn, .channelPin,
   .counterClkTick, .accumulatorClock, .accOverflowIrq, .accInputIrq
);

// >>> dv/tb_pac_regs.sv
// Self-checking bench for the channel value and pulse accumulator registers
`timescale 1ns/1ps
`include "pac_defines.svh"

module tb_pac_regs import pac_pkg::*;;
   logic        core_clk, rst_b, timer_enable_bit, counterClkTick, accumulatorClock;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, channelPin;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdSeen;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, accOverflowIrq, accInputIrq;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rspSeen;
   pac_timer_t  timerIn;
   int          error_cnt = 0, cmp_count = 0, tickCnt = 0, prescCnt = 0;

   pac_regs pac_regs_inst (.core_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .timerIn, .channelPin, .counterClkTick, .accumulatorClock,
      .accOverflowIrq, .accInputIrq);
   pac_timer_model pac_timer_model_inst (.core_clk, .rst_b, .timerOn(timer_enable_bit), .timerOut(timerIn));

   // ****************************************************************
   // Clock, tallies and shared tasks
   // ****************************************************************
   initial begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end

   // Tallies taken mid-cycle, once the ticks settle
   always @(negedge core_clk) begin
      tickCnt += counterClkTick;
      prescCnt += timerIn.prescTick;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Ready is judged mid-cycle, clear of the design's update
   task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
      logic aT, wT, bT;
      bT = 1'h0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (int i = 0; i < 50 && !bT; i++) begin
         @(negedge core_clk);
         aT = s_axi_awvalid & s_axi_awready;
         wT = s_axi_wvalid & s_axi_wready;
         bT = s_axi_bvalid;
         rspSeen = s_axi_bresp;
         @(posedge core_clk);
         if (aT) s_axi_awvalid <= 1'h0;
         if (wT) s_axi_wvalid <= 1'h0;
      end
      s_axi_bready <= 1'h0;
      if (!bT) error_cnt++;
      @(posedge core_clk);
   endtask : axiWr

   task automatic axiRd(input logic [7:0] a);
      logic arT, rT;
      rT = 1'h0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (int i = 0; i < 50 && !rT; i++) begin
         @(negedge core_clk);
         arT = s_axi_arvalid & s_axi_arready;
         rT = s_axi_rvalid;
         rdSeen = s_axi_rdata;
         rspSeen = s_axi_rresp;
         @(posedge core_clk);
         if (arT) s_axi_arvalid <= 1'h0;
      end
      s_axi_rready <= 1'h0;
      if (!rT) error_cnt++;
      @(posedge core_clk);
   endtask : axiRd

   task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
      axiRd(a);
      check(what, rdSeen, exp);
   endtask : rdChk

   // Flags clear only while the timer runs
   task automatic clearFlags();
      timer_enable_bit <= 1'h1;
      axiWr(`PAC_ADDR_ACC_FLAGS, 32'h3);
   endtask : clearFlags

   task automatic pinPulse(input logic v, input int n);
      channelPin[7] <= v;
      cyc(n);
      channelPin[7] <= ~v;
      cyc(n);
   endtask : pinPulse

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic testRegs();
      for (int c = 0; c < 8; c++) rdChk("chan reset", 8'(4 * c), 32'h0);
      axiWr(`PAC_ADDR_ACC_CTL, 32'hFFFF_FFFF);
      check("wresp", 32'(rspSeen), 32'(`PAC_RESP_OKAY));
      rdChk("ctl", `PAC_ADDR_ACC_CTL, 32'h7F);
      axiWr(`PAC_ADDR_ACC_CTL, 32'h0);
      axiRd(8'h30);
      check("rresp", 32'(rspSeen), 32'(`PAC_RESP_SLVERR));
      $display("test registers done");
   endtask : testRegs

   task automatic testCapture();
      timer_enable_bit <= 1'h1;
      cyc(20);
      timer_enable_bit <= 1'h0;
      cyc(3);
      axiWr(8'h0C, 32'h1234);
      rdChk("capture write", 8'h0C, 32'h0);
      channelPin[3] <= 1'h1;
      cyc(5);
      rdChk("capture", 8'h0C, {16'h0000, timerIn.freeCount});
      channelPin[3] <= 1'h0;
      axiWr(`PAC_ADDR_DIR_SEL, 32'h08);
      axiWr(8'h0C, 32'hA5C3);
      channelPin[3] <= 1'h1;
      cyc(5);
      rdChk("compare", 8'h0C, 32'hA5C3);
      $display("test capture done");
   endtask : testCapture

   task automatic testEvent();
      for (int e = 0; e < 2; e++) begin
         channelPin[7] <= ~e[0];
         axiWr(`PAC_ADDR_ACC_CTL, 32'h41 | 32'(e << 4));
         axiWr(`PAC_ADDR_ACC_COUNT, 32'h0);
         clearFlags();
         check("irq clear", 32'(accInputIrq), 32'h0);
         timer_enable_bit <= 1'h0;
         pinPulse(~e[0], 4);
         rdChk("event count", `PAC_ADDR_ACC_COUNT, 32'h1);
         check("input irq", 32'(accInputIrq), 32'h1);
      end
      axiWr(`PAC_ADDR_ACC_CTL, 32'h52);
      axiWr(`PAC_ADDR_ACC_COUNT, 32'hFFFF);
      pinPulse(1'h0, 4);
      rdChk("wrap", `PAC_ADDR_ACC_COUNT, 32'h0);
      check("ovf irq", 32'(accOverflowIrq), 32'h1);
      clearFlags();
      check("ovf clear", 32'(accOverflowIrq), 32'h0);
      $display("test event done");
   endtask : testEvent

   task automatic testGated();
      for (int e = 0; e < 2; e++) begin
         clearFlags();
         channelPin[7] <= e[0];
         axiWr(`PAC_ADDR_ACC_CTL, 32'h61 | 32'(e << 4));
         axiWr(`PAC_ADDR_ACC_COUNT, 32'h0);
         timer_enable_bit <= 1'h0;
         pinPulse(~e[0], 130);
         rdChk("gated off", `PAC_ADDR_ACC_COUNT, 32'h0);
         clearFlags();
         channelPin[7] <= ~e[0];
         cyc(130);
         check("lead flag", 32'(accInputIrq), 32'h0);
         axiRd(`PAC_ADDR_ACC_COUNT);
         channelPin[7] <= e[0];
         cyc(4);
         check("gated count", 32'(rdSeen >= 2 && rdSeen <= 3), 32'h1);
         check("trailing flag", 32'(accInputIrq), 32'h1);
      end
      $display("test gated done");
   endtask : testGated

   task automatic testClkSel();
      int t0, p0;
      channelPin[7] <= 1'h0;
      timer_enable_bit <= 1'h1;
      axiWr(`PAC_ADDR_ACC_CTL, 32'h54);
      t0 = tickCnt;
      repeat (8) pinPulse(1'h1, 3);
      check("sel acc", 32'(tickCnt - t0), 32'h8);
      axiWr(`PAC_ADDR_ACC_CTL, 32'h58);
      t0 = tickCnt;
      repeat (256) pinPulse(1'h1, 3);
      check("sel 256", 32'(tickCnt - t0), 32'h1);
      axiWr(`PAC_ADDR_ACC_CTL, 32'h5C);
      t0 = tickCnt;
      repeat (256) pinPulse(1'h1, 3);
      check("sel 65536", 32'(tickCnt - t0 <= 1), 32'h1);
      for (int c = 0; c < 2; c++) begin
         axiWr(`PAC_ADDR_ACC_CTL, c ? 32'h14 : 32'h40);
         t0 = tickCnt;
         p0 = prescCnt;
         repeat (8) pinPulse(1'h1, 3);
         check("sel presc", 32'(tickCnt - t0), 32'(prescCnt - p0));
      end
      $display("test clock select done");
   endtask : testClkSel

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize

   // Main sequence; every input gets a value at time zero
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      channelPin = 8'h00;
      timer_enable_bit = 1'h0;
      rst_b = 1'h0;
      cyc(2);
      rst_b <= 1'h1;
      testRegs();
      testCapture();
      testEvent();
      testGated();
      testClkSel();
      summarize();
   end

   // Watchdog at over three times the test length
   initial begin
      cyc(20000);
      error_cnt++;
      summarize();
   end
endmodule : tb_pac_regs
